/* fpep_array.sv */
// fpep_array: byte array of the program memory, erase by page or whole.
// assumes one operation per cycle from the sequencer.
`timescale 1ns/1ps
module fpep_array
  import fpep_pkg::*;
#(
  parameter int DEPTH = 16384
)
(
  input wire logic clk_sys,
  input wire logic [13:0] rd_addr,
  output logic [7:0] rd_data,
  input wire logic wr_en,
  input wire logic [13:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic erase_page,
  input wire logic erase_all,
  input wire logic [13:0] erase_addr,
  output logic [7:0] prot_byte
);
  logic [7:0] mem [DEPTH];
  localparam logic [13:0] PROT_IDX = FPEP_PROT_ADDR[13:0];
  localparam logic [13:0] VECT_IDX = FPEP_VECT_BASE[13:0];
  logic in_vect;
  assign in_vect = (erase_addr >= VECT_IDX);
  assign rd_data = mem[rd_addr];
  assign prot_byte = mem[PROT_IDX];
  always_ff @(posedge clk_sys) begin
    for (int i = 0; i < DEPTH; i++) begin
      // [R2] erase returns ones, program clears bits
      if (erase_all) begin
        mem[i] <= FPEP_BYTE_ERASED;
      // [R7] page of 64; a target in the vector area erases that area alone
      end else if (erase_page && (in_vect ? (i >= int'(VECT_IDX)) : (i / FPEP_PAGE_BYTES == int'(erase_addr) / FPEP_PAGE_BYTES))) begin
        mem[i] <= FPEP_BYTE_ERASED;
      end else if (wr_en && i == int'(wr_addr)) begin
        mem[i] <= mem[i] & wr_data;
      end
    end
  end
endmodule : fpep_array

/* fpep_ctrl.sv */
// fpep_ctrl: program/erase sequencer with block protection, APB slave.
// assumes an APB master on clk_sys; array reached through ADDR/DATA/ARRAY regs.
// Behaviour
// [R1] erase unit is a 64-byte page, program at most one 32-byte row
// [R2] erased bit reads one, programmed bit reads zero
// [R3] high voltage sets only with a select active and sequence prepared
// [R4] high voltage bit drives charge pump and array high voltage
// [R5] mass select widens erase to whole array
// [R6] program and erase selects never both one
// [R7] page is 64 aligned bytes; vector area is its own page; here a page erase aimed at FFC0 to FFCF also clears the vector area
// [R8] software page erase sequence order
// [R9] software mass erase sequence order
// [R10] mass erase inhibited unless protect byte is all ones
// [R11] program row 32 aligned bytes, one row at a time
// [R12] program select latches address and data; software steps follow
// [R13] software never reprograms a byte without erase
// [R14] software keeps address changes below max program time
// [R15] software avoids top address write while high voltage on
// [R16] software runs elsewhere and keeps step order
// [R17] protected target refuses high voltage
// [R18] software reads protect byte before setting high voltage
// [R19] zero protects all, ones none, low values protect all; here only zero puts the start at the array base
// [R20] protect byte forms start address bits 13 to 6
// [R21] protected range and protect byte locked unless test voltage
// [R22] software targets protect location for monitor mass erase
`timescale 1ns/1ps
module fpep_ctrl
  import fpep_pkg::*;
#(
  parameter int DEPTH = 16384
)
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic test_high_voltage,
  output logic charge_pump_on
);
  logic [3:0] ctrl_reg;
  logic [15:0] addr_reg;
  logic [7:0] data_reg;
  logic prot_read_reg, latched_reg, hv_ok_reg;
  logic [15:0] tgt_reg;
  logic wr, rd, apb_acc;
  logic [7:0] rd_byte, prot_byte;
  logic [15:0] prot_start;
  logic locked, any_prot, tgt_lock;
  logic arr_wr, er_pg, er_all;
  logic [31:0] rdata_next;

  assign apb_acc = psel && penable && pready;
  assign wr = apb_acc && pwrite;
  assign rd = apb_acc && !pwrite;

  fpep_prot u_prot (
    .prot_byte(prot_byte),
    .target_addr(tgt_reg),
    .prot_start(prot_start),
    .target_locked(locked),
    .any_protect(any_prot)
  );

  // [R21] test voltage lifts the lock
  assign tgt_lock = !test_high_voltage && (locked || (any_prot && tgt_reg == FPEP_PROT_ADDR));

  fpep_array #(.DEPTH(DEPTH)) u_array (
    .clk_sys(clk_sys),
    .rd_addr(addr_reg[13:0]),
    .rd_data(rd_byte),
    .wr_en(arr_wr),
    .wr_addr(addr_reg[13:0]),
    .wr_data(data_reg),
    .erase_page(er_pg),
    .erase_all(er_all),
    .erase_addr(tgt_reg[13:0]),
    .prot_byte(prot_byte)
  );

  // single-cycle answers, no wait states
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      pready <= 1'b0;
    end else begin
      pready <= psel && !penable;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= psel && !penable && !(paddr inside {FPEP_OFF_CTRL, FPEP_OFF_PROT, FPEP_OFF_STAT,
                                                   FPEP_OFF_ADDR, FPEP_OFF_DATA, FPEP_OFF_ARRAY});
    end
  end

  always_comb begin
    rdata_next = 32'h0000_0000;
    case (paddr)
      FPEP_OFF_CTRL: rdata_next = {28'h0000000, ctrl_reg};
      FPEP_OFF_PROT: rdata_next = {24'h000000, prot_byte};
      FPEP_OFF_STAT: rdata_next = {13'h0000, hv_ok_reg, latched_reg, prot_read_reg, prot_start};
      FPEP_OFF_ADDR: rdata_next = {16'h0000, addr_reg};
      FPEP_OFF_DATA: rdata_next = {24'h000000, data_reg};
      FPEP_OFF_ARRAY: rdata_next = {24'h000000, rd_byte};
      default: rdata_next = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rdata_next;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      addr_reg <= 16'h0000;
    end else if (wr && paddr == FPEP_OFF_ADDR) begin
      addr_reg <= pwdata[15:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      data_reg <= 8'h00;
    end else if (wr && paddr == FPEP_OFF_DATA) begin
      data_reg <= pwdata[7:0];
    end
  end

  logic arr_write_hit;
  assign arr_write_hit = wr && paddr == FPEP_OFF_ARRAY && addr_reg >= FPEP_ARRAY_BASE;

  // [R18] protect read observed after select
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      prot_read_reg <= 1'b0;
    end else if (!(ctrl_reg[FPEP_BIT_PGM] || ctrl_reg[FPEP_BIT_ERASE])) begin
      prot_read_reg <= 1'b0;
    end else if (rd && paddr == FPEP_OFF_PROT) begin
      prot_read_reg <= 1'b1;
    end
  end

  // [R12] array write after protect read, before high voltage, latches the target
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      latched_reg <= 1'b0;
      tgt_reg <= 16'h0000;
    end else if (!(ctrl_reg[FPEP_BIT_PGM] || ctrl_reg[FPEP_BIT_ERASE])) begin
      latched_reg <= 1'b0;
    end else if (arr_write_hit && !ctrl_reg[FPEP_BIT_HIGH_VOLTAGE_ENABLE] && prot_read_reg) begin
      latched_reg <= 1'b1;
      tgt_reg <= addr_reg;
    end
  end

  // [R10] mass blocked by any protection without test voltage; [R17] locked target blocked
  always_comb begin
    hv_ok_reg = latched_reg && !tgt_lock &&
                !(ctrl_reg[FPEP_BIT_ERASE] && ctrl_reg[FPEP_BIT_MASS] && any_prot && !test_high_voltage);
  end

  logic [3:0] ctrl_next;
  always_comb begin
    ctrl_next = ctrl_reg;
    if (wr && paddr == FPEP_OFF_CTRL) begin
      ctrl_next[FPEP_BIT_MASS] = pwdata[FPEP_BIT_MASS];
      // [R6] interlock: both requested or other held keeps state
      if (!(pwdata[FPEP_BIT_PGM] && (pwdata[FPEP_BIT_ERASE] || ctrl_reg[FPEP_BIT_ERASE]))) begin
        ctrl_next[FPEP_BIT_PGM] = pwdata[FPEP_BIT_PGM];
      end
      if (!(pwdata[FPEP_BIT_ERASE] && (pwdata[FPEP_BIT_PGM] || ctrl_reg[FPEP_BIT_PGM]))) begin
        ctrl_next[FPEP_BIT_ERASE] = pwdata[FPEP_BIT_ERASE];
      end
      // [R3] set only when prepared; clear always allowed
      if (!pwdata[FPEP_BIT_HIGH_VOLTAGE_ENABLE]) begin
        ctrl_next[FPEP_BIT_HIGH_VOLTAGE_ENABLE] = 1'b0;
      end else if (hv_ok_reg && (ctrl_reg[FPEP_BIT_PGM] || ctrl_reg[FPEP_BIT_ERASE])) begin
        ctrl_next[FPEP_BIT_HIGH_VOLTAGE_ENABLE] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      ctrl_reg <= FPEP_CTRL_RESET[3:0];
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  // [R4] pump follows high voltage bit
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      charge_pump_on <= 1'b0;
    end else begin
      charge_pump_on <= ctrl_next[FPEP_BIT_HIGH_VOLTAGE_ENABLE];
    end
  end

  // [R11] program limited to latched 32-byte row
  assign arr_wr = arr_write_hit && ctrl_reg[FPEP_BIT_PGM] && ctrl_reg[FPEP_BIT_HIGH_VOLTAGE_ENABLE] && hv_ok_reg &&
                  (addr_reg[15:5] == tgt_reg[15:5]) &&
                  (test_high_voltage || !(any_prot && (addr_reg >= prot_start || addr_reg == FPEP_PROT_ADDR)));
  // [R1] erase fires as erase select drops under high voltage
  // [R5] mass selects whole array
  assign er_pg = wr && paddr == FPEP_OFF_CTRL && ctrl_reg[FPEP_BIT_ERASE] && !pwdata[FPEP_BIT_ERASE] &&
                 ctrl_reg[FPEP_BIT_HIGH_VOLTAGE_ENABLE] && hv_ok_reg && !ctrl_reg[FPEP_BIT_MASS];
  assign er_all = wr && paddr == FPEP_OFF_CTRL && ctrl_reg[FPEP_BIT_ERASE] && !pwdata[FPEP_BIT_ERASE] &&
                  ctrl_reg[FPEP_BIT_HIGH_VOLTAGE_ENABLE] && hv_ok_reg && ctrl_reg[FPEP_BIT_MASS];

  property p_excl;
    @(posedge clk_sys) disable iff (!reset_n)
    !(ctrl_reg[FPEP_BIT_PGM] && ctrl_reg[FPEP_BIT_ERASE]);
  endproperty
  a_excl: assert property (p_excl) else $error("program and erase both set"); // [R6]

  property p_hv_needs_sel;
    @(posedge clk_sys) disable iff (!reset_n)
    $rose(ctrl_reg[FPEP_BIT_HIGH_VOLTAGE_ENABLE]) |-> ($past(ctrl_reg[FPEP_BIT_PGM]) || $past(ctrl_reg[FPEP_BIT_ERASE])) && $past(latched_reg);
  endproperty
  a_hv_needs_sel: assert property (p_hv_needs_sel) else $error("high voltage set without preparation"); // [R3]

  property p_pump;
    @(posedge clk_sys) disable iff (!reset_n)
    ##1 (charge_pump_on == ctrl_reg[FPEP_BIT_HIGH_VOLTAGE_ENABLE]);
  endproperty
  a_pump: assert property (p_pump) else $error("pump differs from high voltage bit"); // [R4]

  property p_lock;
    @(posedge clk_sys) disable iff (!reset_n)
    $rose(ctrl_reg[FPEP_BIT_HIGH_VOLTAGE_ENABLE]) |-> !$past(tgt_lock);
  endproperty
  a_lock: assert property (p_lock) else $error("high voltage on locked target"); // [R17]

  property p_mass;
    @(posedge clk_sys) disable iff (!reset_n)
    er_all |-> (prot_byte == FPEP_PROT_ERASED || test_high_voltage);
  endproperty
  a_mass: assert property (p_mass) else $error("mass erase while protected"); // [R10]

  property p_start;
    @(posedge clk_sys) disable iff (!reset_n)
    prot_start[15:14] == 2'b11 && prot_start[5:0] == 6'h00 && prot_start[13:6] == prot_byte;
  endproperty
  a_start: assert property (p_start) else $error("protect start malformed"); // [R20]

  property p_row;
    @(posedge clk_sys) disable iff (!reset_n)
    arr_wr |-> addr_reg[15:5] == tgt_reg[15:5];
  endproperty
  a_row: assert property (p_row) else $error("program outside row"); // [R11]

  property p_protlock;
    @(posedge clk_sys) disable iff (!reset_n)
    (arr_wr || er_pg) && any_prot && !test_high_voltage |-> tgt_reg < prot_start && tgt_reg != FPEP_PROT_ADDR;
  endproperty
  a_protlock: assert property (p_protlock) else $error("write in protected range"); // [R21]

  property p_hv_prot_read;
    @(posedge clk_sys) disable iff (!reset_n)
    $rose(ctrl_reg[FPEP_BIT_HIGH_VOLTAGE_ENABLE]) |-> $past(prot_read_reg);
  endproperty
  a_hv_prot_read: assert property (p_hv_prot_read) else $error("high voltage set before protect read"); // [R18]

  property p_mass_hv;
    @(posedge clk_sys) disable iff (!reset_n)
    $rose(ctrl_reg[FPEP_BIT_HIGH_VOLTAGE_ENABLE]) && ctrl_reg[FPEP_BIT_ERASE] && ctrl_reg[FPEP_BIT_MASS] |->
      !$past(any_prot) || $past(test_high_voltage);
  endproperty
  a_mass_hv: assert property (p_mass_hv) else $error("high voltage for mass erase while protected"); // [R10]

  property p_prog_prepared;
    @(posedge clk_sys) disable iff (!reset_n)
    arr_wr |-> latched_reg && prot_read_reg && ctrl_reg[FPEP_BIT_HIGH_VOLTAGE_ENABLE];
  endproperty
  a_prog_prepared: assert property (p_prog_prepared) else $error("program without latched target"); // [R12]

  property p_erase_hv;
    @(posedge clk_sys) disable iff (!reset_n)
    (er_pg || er_all) |-> ctrl_reg[FPEP_BIT_HIGH_VOLTAGE_ENABLE] && !ctrl_reg[FPEP_BIT_PGM];
  endproperty
  a_erase_hv: assert property (p_erase_hv) else $error("erase without high voltage"); // [R4]

  property p_ones_open;
    @(posedge clk_sys) disable iff (!reset_n)
    prot_byte == FPEP_PROT_ERASED |-> !any_prot && !locked;
  endproperty
  a_ones_open: assert property (p_ones_open) else $error("erased protect byte still locks"); // [R19]

  property p_both_req;
    @(posedge clk_sys) disable iff (!reset_n)
    wr && paddr == FPEP_OFF_CTRL && pwdata[FPEP_BIT_PGM] && pwdata[FPEP_BIT_ERASE] |=>
      ctrl_reg[FPEP_BIT_PGM] == $past(ctrl_reg[FPEP_BIT_PGM]) && ctrl_reg[FPEP_BIT_ERASE] == $past(ctrl_reg[FPEP_BIT_ERASE]);
  endproperty
  a_both_req: assert property (p_both_req) else $error("both selects taken together"); // [R6]
endmodule : fpep_ctrl

/* fpep_pkg.sv */
// fpep_pkg: shared constants for the nonvolatile program memory sequencer.
// assumes a 16-bit cpu address space with the array at its top.
package fpep_pkg;
  localparam logic [7:0] FPEP_OFF_CTRL = 8'h00;
  localparam logic [7:0] FPEP_OFF_PROT = 8'h04;
  localparam logic [7:0] FPEP_OFF_STAT = 8'h08;
  localparam logic [7:0] FPEP_OFF_ADDR = 8'h0C;
  localparam logic [7:0] FPEP_OFF_DATA = 8'h10;
  localparam logic [7:0] FPEP_OFF_ARRAY = 8'h14;
  localparam int FPEP_BIT_PGM = 0;
  localparam int FPEP_BIT_ERASE = 1;
  localparam int FPEP_BIT_MASS = 2;
  localparam int FPEP_BIT_HIGH_VOLTAGE_ENABLE = 3;
  localparam logic [7:0] FPEP_CTRL_RESET = 8'h00;
  localparam logic [7:0] FPEP_PROT_ERASED = 8'hFF;
  localparam logic [7:0] FPEP_BYTE_ERASED = 8'hFF;
  localparam logic [15:0] FPEP_ARRAY_BASE = 16'hC000;
  localparam logic [15:0] FPEP_PROT_ADDR = 16'hFFBE;
  localparam logic [15:0] FPEP_VECT_BASE = 16'hFFD0;
  localparam int FPEP_PAGE_BYTES = 64;
  localparam int FPEP_ROW_BYTES = 32;
  localparam int FPEP_VECT_BYTES = 48;
  typedef enum logic [1:0] {FPEP_OP_NONE, FPEP_OP_PGM, FPEP_OP_PAGE, FPEP_OP_MASS} fpep_op_t;
endpackage : fpep_pkg

/* fpep_prot.sv */
// fpep_prot: protect start decode and range check.
// assumes the protect byte is presented as a level.
`timescale 1ns/1ps
module fpep_prot
  import fpep_pkg::*;
(
  input wire logic [7:0] prot_byte,
  input wire logic [15:0] target_addr,
  output logic [15:0] prot_start,
  output logic target_locked,
  output logic any_protect
);
  // [R20] start address build
  assign prot_start = {2'b11, prot_byte, 6'h00};
  // [R19] all ones unprotected
  assign any_protect = (prot_byte != FPEP_PROT_ERASED);
  // [R19] zero covers whole array by compare
  assign target_locked = any_protect && (target_addr >= prot_start);
endmodule : fpep_prot

/* tb_top.sv */
// tb_top: self-checking bench for the program memory sequencer over apb.
// assumes fpep_ctrl as top; array starts unknown, so it is first wiped.
`timescale 1ns/1ps
module tb_top
  import fpep_pkg::*;
;
  typedef struct {logic [31:0] d; logic [31:0] m; logic e;} fpep_exp_t;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic test_high_voltage = 1'b1;
  logic charge_pump_on;
  fpep_exp_t exp_q[$];
  int num_errors = 0;
  int tests_run = 0;
  int seed = 32'hf31055de;
  logic [15:0] off;
  logic [7:0] d1, d2, d3;

  fpep_ctrl u_dut (.clk_sys(clk_sys), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .test_high_voltage(test_high_voltage), .charge_pump_on(charge_pump_on));

  initial begin
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic complete_run;
    if (num_errors == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // one transfer; the expectation is queued for the monitor
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] e,
    input logic [31:0] m, input logic err);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    exp_q.push_back('{d: e, m: m, e: err});
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    // only the watchdog ends a wait
    while (pready !== 1'b1) begin
      @(posedge clk_sys);
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 32'h0, 32'h0, 1'b0);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    apb(1'b0, a, 32'h0, e, m, 1'b0);
  endtask : rd

  task automatic cp_chk(input logic e);
    @(negedge clk_sys);
    chk("charge_pump_on", {31'h0, e}, {31'h0, charge_pump_on});
  endtask : cp_chk

  task automatic arr_rd(input logic [15:0] a, input logic [7:0] e);
    wr(FPEP_OFF_ADDR, {16'h0, a});
    rd(FPEP_OFF_ARRAY, {24'h0, e}, 32'hFF);
  endtask : arr_rd

  // each byte programmed once per erase
  task automatic pb(input logic [15:0] a, input logic [7:0] d);
    wr(FPEP_OFF_ADDR, {16'h0, a});
    wr(FPEP_OFF_DATA, {24'h0, d});
    wr(FPEP_OFF_ARRAY, {24'h0, d});
  endtask : pb

  // select, protect read, latch target, then ask for high voltage
  // steps kept in order
  task automatic seq(input logic [3:0] c, input logic [15:0] a, input logic hv);
    wr(FPEP_OFF_CTRL, {28'h0, c});
    rd(FPEP_OFF_PROT, 32'h0, 32'h0);
    wr(FPEP_OFF_ADDR, {16'h0, a});
    wr(FPEP_OFF_ARRAY, 32'h0);
    wr(FPEP_OFF_CTRL, {28'h0, c | 4'h8});
    cp_chk(hv);
  endtask : seq

  task automatic fin(input logic hv);
    if (hv) begin
      wr(FPEP_OFF_CTRL, 32'h8);
    end
    wr(FPEP_OFF_CTRL, 32'h0);
    cp_chk(1'b0);
  endtask : fin

  // monitor: each completed transfer takes the oldest note
  always @(posedge clk_sys) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
      if (exp_q.size() == 0) begin
        chk("queue", 32'h1, 32'h0);
      end else begin
        chk("prdata", exp_q[0].d & exp_q[0].m, prdata & exp_q[0].m);
        chk("pslverr", {31'h0, exp_q[0].e}, {31'h0, pslverr});
        void'(exp_q.pop_front());
      end
    end
  end

  initial begin
    #200us;
    num_errors++;
    complete_run();
  end

  initial begin
    repeat (8) @(posedge clk_sys);
    reset_n <= 1'b1;
    rd(FPEP_OFF_CTRL, {24'h0, FPEP_CTRL_RESET}, 32'hFF);
    apb(1'b0, 8'h18, 32'h0, 32'h0, 32'hFFFFFFFF, 1'b1);
    // wipe with the test voltage present; lifts any lock
    // mass prep write aimed at protect byte
    seq(4'h6, FPEP_PROT_ADDR, 1'b1);
    fin(1'b1);
    rd(FPEP_OFF_PROT, {24'h0, FPEP_PROT_ERASED}, 32'hFF);
    arr_rd(16'hE123, FPEP_BYTE_ERASED);
    test_high_voltage <= 1'b0;
    wr(FPEP_OFF_CTRL, 32'h8);
    cp_chk(1'b0);
    rd(FPEP_OFF_CTRL, 32'h0, 32'hF);
    wr(FPEP_OFF_CTRL, 32'h3);
    rd(FPEP_OFF_CTRL, 32'h0, 32'hF);
    off = 16'($unsigned($random(seed))) & 16'h001E;
    d1 = 8'($random(seed));
    d2 = 8'($random(seed));
    d3 = 8'($random(seed));
    seq(4'h1, FPEP_ARRAY_BASE + off, 1'b1);
    pb(FPEP_ARRAY_BASE + off, d1);
    pb(FPEP_ARRAY_BASE + off + 16'h1, d2);
    fin(1'b1);
    arr_rd(FPEP_ARRAY_BASE + off, d1);
    arr_rd(FPEP_ARRAY_BASE + off + 16'h1, d2);
    seq(4'h1, FPEP_ARRAY_BASE + 16'h40, 1'b1);
    pb(FPEP_ARRAY_BASE + 16'h40, d3);
    fin(1'b1);
    // page erase must stop at the 64-byte boundary
    seq(4'h2, FPEP_ARRAY_BASE + 16'h10, 1'b1);
    fin(1'b1);
    arr_rd(FPEP_ARRAY_BASE + off, FPEP_BYTE_ERASED);
    arr_rd(FPEP_ARRAY_BASE + 16'h40, d3);
    seq(4'h1, FPEP_PROT_ADDR, 1'b1);
    pb(FPEP_PROT_ADDR, 8'hFE);
    fin(1'b1);
    rd(FPEP_OFF_STAT, 32'h0000FF80, 32'h0000FFFF);
    seq(4'h1, FPEP_VECT_BASE, 1'b0);
    rd(FPEP_OFF_CTRL, 32'h1, 32'hF);
    fin(1'b0);
    seq(4'h1, FPEP_PROT_ADDR, 1'b0);
    fin(1'b0);
    seq(4'h6, FPEP_ARRAY_BASE, 1'b0);
    rd(FPEP_OFF_CTRL, 32'h6, 32'hF);
    fin(1'b0);
    seq(4'h1, FPEP_ARRAY_BASE + 16'h80, 1'b1);
    fin(1'b1);
    repeat (4) @(posedge clk_sys);
    complete_run();
  end
endmodule : tb_top
